// *** hw/crc_ctrl.sv ***
// charger supervision: settings decode, soft start, protection and foldback
`timescale 1ns/1ps
`include "crc_defs.svh"
// Function
// - voltage setting becomes a 7-bit per-cell code, 6.25 mV steps from 4 V.
// - settings 12 V to 14.4 V mean three cells, 18.75 mV per step.
// - settings 16 V to 19.2 V mean four cells, 25 mV per step.
// - exactly 9 V is valid; thresholds then use two cells.
// - below 12 V except 9 V: out-of-range flag, converter held off.
// - 14.4 V up to below 16 V: out-of-range flag, converter held off.
// - 19.2 V or more: flag set, charging allowed, target clamped 19.175 V.
// - on enable the current reference climbs in eight equal steps to target.
// - each step lasts about 1 ms, target reached about 7 ms after enable.
// - ramp restarts at enable and on each return from fault or suspend.
// - high side off at once on fault, suspend, sleep, undervoltage.
// - mode bit 3 picks monitor source: low input current, high charge current.
// - high side off while charge current above 200 percent; resumes itself.
// - battery below 2 V forces both switches off, then regulation resumes.
// - converter off above 145 C until below 130 C.
// - depleted threshold 2.2 V per cell plus 100 mV per code, times cells.
// - shorted below 1.7 V per cell, leaves above 1.9 V, 1 s deglitch.
// - shorted state regulates at C/8, back to C after leaving.
// - input current is limited against the input limit register.
// - currents from bits 13:7, 128 mA weight, clamp high, zero disables.
module crc_ctrl
	import crc_pkg::*;
#(
	parameter int STEP_CYC = `CRC_STEP_CYC,
	parameter int DEGL_CYC = `CRC_DEGL_CYC
) (
	input  wire logic        core_clk,   // 25 MHz system clock
	input  wire logic        rst_n,      // sync reset, active low
	input  wire logic        scl_in,     // smbus clock pin
	input  wire logic        sda_in,     // smbus data pin level
	output logic             sda_out,    // smbus data drive value
	output logic             sda_oe_n,   // smbus data drive enable, active low
	input  wire crc_pins_t   pins,       // comparator and supervisor levels
	input  wire logic [15:0] bat_mv,     // sensed battery voltage, mV
	output logic             hs_gate_en, // high-side switch allowed
	output logic             ls_gate_en, // low-side switch allowed
	output logic [6:0]       ichg_ref,   // charge current reference code
	output logic [6:0]       iin_ref,    // input current limit code
	output logic [6:0]       vreg_code,  // per-cell voltage code
	output logic [2:0]       cell_count, // decoded cell count
	output logic             mon_sel,    // monitor source, high = charge
	output logic             vor_flag,   // voltage_out_of_range_flag
	output logic             depleted,   // below depleted_pack_threshold
	output logic             shorted     // shorted_pack_condition
);
	// ---------------------------------------------------------------
	// decode functions
	// ---------------------------------------------------------------
	function automatic logic [6:0] cur_code(input logic [15:0] w);
		if (w[15:14] != 2'h0) begin
			return 7'h7f;
		end
		return w[`CRC_CUR_MSB:`CRC_CUR_LSB];
	endfunction : cur_code

	function automatic crc_vdec_t volt_dec(input logic [15:0] w);
		crc_vdec_t  r;
		logic [15:0] v;
		logic [17:0] d;
		v = {w[15:1], 1'b0};
		d = 18'h00000;
		r = '{code: 7'h00, cells: 3'h4, voltage_out_of_range_flag: 1'b1, allow: 1'b0};
		if (v == `CRC_V_WAKE) begin
			r = '{code: `CRC_WAKE_CODE, cells: 3'h2, voltage_out_of_range_flag: 1'b0, allow: 1'b1};
		end else if (v >= `CRC_V3_LO && v < `CRC_V3_HI) begin
			d = {2'h0, v - `CRC_V3_LO} << 2;
			d = d / `CRC_STEP3_X4;
			r = '{code: d[6:0], cells: 3'h3, voltage_out_of_range_flag: 1'b0, allow: 1'b1};
		end else if (v >= `CRC_V4_LO && v < `CRC_V4_HI) begin
			d = {2'h0, (v - `CRC_V4_LO) / `CRC_STEP4_MV};
			r = '{code: d[6:0], cells: 3'h4, voltage_out_of_range_flag: 1'b0, allow: 1'b1};
		end else if (v >= `CRC_V4_HI) begin
			r = '{code: 7'h7f, cells: 3'h4, voltage_out_of_range_flag: 1'b1, allow: 1'b1};
		end else if (v < `CRC_V3_LO) begin
			r.cells = 3'h3;
		end
		return r;
	endfunction : volt_dec

	function automatic logic [15:0] per_cell(input logic [2:0] n, input logic [15:0] mv);
		return 16'(n * mv);
	endfunction : per_cell

	// ---------------------------------------------------------------
	// registers and bus
	// ---------------------------------------------------------------
	logic [15:0] mode_reg, chg_reg, inlim_reg, volt_reg;
	logic [15:0] mode_next, chg_next, inlim_next, volt_next;
	logic [7:0]  rd_cmd;
	logic [15:0] rd_word;
	logic        wr_stb;
	crc_wr_t     wr;
	logic        hot_reg;
	logic        active_reg;

	crc_smbus u_smbus (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe_n (sda_oe_n),
		.rd_cmd   (rd_cmd),
		.rd_word  (rd_word),
		.wr_stb   (wr_stb),
		.wr       (wr)
	);

	always_comb begin
		mode_next  = mode_reg;
		chg_next   = chg_reg;
		inlim_next = inlim_reg;
		volt_next  = volt_reg;
		if (wr_stb) begin
			case (wr.cmd)
				`CRC_REG_MODE:  mode_next  = wr.data;
				`CRC_REG_CHG:   chg_next   = wr.data;
				`CRC_REG_INLIM: inlim_next = wr.data;
				`CRC_REG_VOLT:  volt_next  = wr.data;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (rd_cmd)
			`CRC_REG_MODE:  rd_word = mode_reg;
			`CRC_REG_CHG:   rd_word = chg_reg;
			`CRC_REG_INLIM: rd_word = inlim_reg;
			`CRC_REG_VOLT:  rd_word = volt_reg;
			`CRC_REG_STAT:  rd_word = {10'h000, hot_reg, shorted, depleted,
				hs_gate_en, active_reg, vor_flag};
			default:        rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_reg  <= `CRC_WORD_RST;
			chg_reg   <= `CRC_WORD_RST;
			inlim_reg <= `CRC_WORD_RST;
			volt_reg  <= `CRC_WORD_RST;
		end else begin
			mode_reg  <= mode_next;
			chg_reg   <= chg_next;
			inlim_reg <= inlim_next;
			volt_reg  <= volt_next;
		end
	end

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	crc_pins_t   pins_m_reg, pins_s_reg;
	logic [15:0] bat_m_reg, bat_s_reg;
	logic [15:0] bat_p_reg, bat_v_reg, bat_v_next;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pins_m_reg <= '0;
			pins_s_reg <= '0;
			bat_m_reg  <= 16'h0000;
			bat_s_reg  <= 16'h0000;
			bat_p_reg  <= 16'h0000;
			bat_v_reg  <= 16'h0000;
		end else begin
			pins_m_reg <= pins;
			pins_s_reg <= pins_m_reg;
			bat_m_reg  <= bat_mv;
			bat_s_reg  <= bat_m_reg;
			bat_p_reg  <= bat_s_reg;
			bat_v_reg  <= bat_v_next;
		end
	end

	// ---------------------------------------------------------------
	// battery word capture
	// ---------------------------------------------------------------
	// taken only when two samples agree, so a torn word never reaches the compares
	always_comb begin
		bat_v_next = bat_v_reg;
		if (bat_s_reg == bat_p_reg) begin
			bat_v_next = bat_s_reg;
		end
	end

	// ---------------------------------------------------------------
	// supervision and soft start
	// ---------------------------------------------------------------
	crc_vdec_t  vd;
	logic [6:0] chg_code, in_code, target;
	logic       enable, run_now, ramp_tick, degl_tick, degl_run;
	logic       below_short, above_short, below_2v, below_dep;
	logic       hot_next, active_next;
	logic       lo2v_reg, shorted_next, zero_next;
	logic       hs_next, ls_next;
	logic [3:0] step_reg, step_next;
	logic [10:0] ramp_prod;

	assign vd       = volt_dec(volt_reg);
	assign chg_code = cur_code(chg_reg);
	assign in_code  = cur_code(inlim_reg);
	assign enable   = vd.allow && chg_code != 7'h00 && in_code != 7'h00;
	assign run_now  = enable && !pins_s_reg.fault && !pins_s_reg.sleep
		&& !pins_s_reg.uv && !hot_next;
	assign below_2v    = bat_v_reg < `CRC_ZERO_DUTY;
	assign below_short = bat_v_reg < per_cell(vd.cells, `CRC_SHORT_IN);
	assign above_short = bat_v_reg > per_cell(vd.cells, `CRC_SHORT_OUT);
	assign below_dep   = bat_v_reg < per_cell(vd.cells, `CRC_DEP_BASE + `CRC_DEP_INC
		* {13'h0000, mode_reg[`CRC_DEP_MSB:`CRC_DEP_LSB]});
	assign degl_run = shorted ? above_short : below_short;
	assign target   = shorted ? {3'h0, chg_code[6:3]} : chg_code;
	assign ramp_prod = 11'(target * step_reg);

	crc_timer #(.LIMIT(STEP_CYC)) u_step_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (active_reg && step_reg < `CRC_RAMP_STEPS),
		.done     (ramp_tick)
	);

	crc_timer #(.LIMIT(DEGL_CYC)) u_degl_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (degl_run),
		.done     (degl_tick)
	);

	always_comb begin
		hot_next = hot_reg;
		if (pins_s_reg.hot) begin
			hot_next = 1'b1;
		end else if (pins_s_reg.cool) begin
			hot_next = 1'b0;
		end
		active_next  = run_now;
		shorted_next = (degl_run && degl_tick) ? ~shorted : shorted;
		zero_next    = below_2v && !lo2v_reg;
		step_next    = step_reg;
		if (!run_now) begin
			step_next = 4'h0;
		end else if (!active_reg) begin
			step_next = 4'h1;
		end else if (ramp_tick) begin
			step_next = step_reg + 4'h1;
		end
		hs_next = run_now && !pins_s_reg.oc && !zero_next;
		ls_next = run_now && !zero_next;
	end

	// ---------------------------------------------------------------
	// output next values
	// ---------------------------------------------------------------
	logic [6:0] ichg_next;
	logic [6:0] iin_next;

	always_comb begin
		ichg_next = ramp_prod[9:3];
		iin_next  = 7'h00;
		if (enable) begin
			iin_next = in_code;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hot_reg    <= 1'b0;
			active_reg <= 1'b0;
			shorted    <= 1'b0;
			lo2v_reg   <= 1'b1;
			step_reg   <= 4'h0;
			hs_gate_en <= 1'b0;
			ls_gate_en <= 1'b0;
			ichg_ref   <= 7'h00;
			iin_ref    <= 7'h00;
			vreg_code  <= 7'h00;
			cell_count <= 3'h0;
			mon_sel    <= 1'b0;
			vor_flag   <= 1'b0;
			depleted   <= 1'b0;
		end else begin
			hot_reg    <= hot_next;
			active_reg <= active_next;
			shorted    <= shorted_next;
			lo2v_reg   <= below_2v;
			step_reg   <= step_next;
			hs_gate_en <= hs_next;
			ls_gate_en <= ls_next;
			ichg_ref   <= ichg_next;
			iin_ref    <= iin_next;
			vreg_code  <= vd.code;
			cell_count <= vd.cells;
			mon_sel    <= mode_reg[`CRC_MON_BIT];
			vor_flag   <= vd.voltage_out_of_range_flag;
			depleted   <= below_dep;
		end
	end
endmodule : crc_ctrl

// *** hw/crc_defs.svh ***
// register offsets, field positions, thresholds and timing counts
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// ---------------------------------------------------------------
// bus address and register offsets
// ---------------------------------------------------------------
`define CRC_SMB_ADDR   7'h09
`define CRC_REG_MODE   8'h12
`define CRC_REG_CHG    8'h14
`define CRC_REG_VOLT   8'h15
`define CRC_REG_STAT   8'h16
`define CRC_REG_INLIM  8'h3f

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CRC_MON_BIT    3
`define CRC_DEP_MSB    11
`define CRC_DEP_LSB    9
`define CRC_CUR_MSB    13
`define CRC_CUR_LSB    7
`define CRC_WORD_RST   16'h0000

// ---------------------------------------------------------------
// voltages in millivolts
// ---------------------------------------------------------------
`define CRC_V_WAKE     16'd9000
`define CRC_V3_LO      16'd12000
`define CRC_V3_HI      16'd14400
`define CRC_V4_LO      16'd16000
`define CRC_V4_HI      16'd19200
`define CRC_STEP4_MV   16'd25
`define CRC_STEP3_X4   18'd75
`define CRC_WAKE_CODE  7'h50
`define CRC_SHORT_IN   16'd1700
`define CRC_SHORT_OUT  16'd1900
`define CRC_DEP_BASE   16'd2200
`define CRC_DEP_INC    16'd100
`define CRC_ZERO_DUTY  16'd2000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CRC_CLK_HZ     25000000
`define CRC_STEP_MS    1
`define CRC_DEGL_S     1
`define CRC_STEP_CYC   ((`CRC_CLK_HZ / 1000) * `CRC_STEP_MS)
`define CRC_DEGL_CYC   (`CRC_CLK_HZ * `CRC_DEGL_S)
`define CRC_RAMP_STEPS 4'd8

`endif

// *** hw/crc_pkg.sv ***
// types shared by the charger control block
package crc_pkg;

	typedef enum logic [2:0] {
		SMB_IDLE = 3'b000,
		SMB_RXB  = 3'b001,
		SMB_ACK  = 3'b010,
		SMB_TXB  = 3'b011,
		SMB_MACK = 3'b100
	} crc_smb_state_t;

	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] data;
	} crc_wr_t;

	typedef struct packed {
		logic       fault;
		logic       sleep;
		logic       uv;
		logic       oc;
		logic       hot;
		logic       cool;
	} crc_pins_t;

	typedef struct packed {
		logic [6:0] code;
		logic [2:0] cells;
		logic       voltage_out_of_range_flag;
		logic       allow;
	} crc_vdec_t;

endpackage : crc_pkg

// *** hw/crc_timer.sv ***
// interval counter: pulses after a run of LIMIT cycles, restarts when run drops
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_timer #(
	parameter int LIMIT = 25000
) (
	input  wire logic core_clk, // system clock
	input  wire logic rst_n,    // sync reset, active low
	input  wire logic run,      // count while high
	output logic      done      // one-cycle pulse per interval
);
	logic [24:0] cnt_reg;
	logic [24:0] cnt_next;
	logic        done_next;

	always_comb begin
		cnt_next  = 25'h0000000;
		done_next = 1'b0;
		if (run) begin
			if (cnt_reg == 25'(LIMIT - 1)) begin
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 25'h0000001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_reg <= 25'h0000000;
			done    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done    <= done_next;
		end
	end
endmodule : crc_timer

// *** hw/crc_smbus.sv ***
// smbus word read/write slave
`timescale 1ns/1ps
`include "crc_defs.svh"
module crc_smbus
	import crc_pkg::*;
(
	input  wire logic        core_clk, // system clock
	input  wire logic        rst_n,    // sync reset, active low
	input  wire logic        scl_in,   // clock pin level
	input  wire logic        sda_in,   // data pin level
	output logic             sda_out,  // data pin drive value
	output logic             sda_oe_n, // data drive enable, active low
	output logic [7:0]       rd_cmd,   // command being read
	input  wire logic [15:0] rd_word,  // word for rd_cmd
	output logic             wr_stb,   // one-cycle write strobe
	output crc_wr_t          wr        // write command and word
);
	logic [1:0]     scl_sync_reg, sda_sync_reg;
	logic           scl_q_reg, sda_q_reg;
	crc_smb_state_t st_reg, st_next;
	logic [7:0]     sh_reg, sh_next, cmd_reg, cmd_next, lo_reg, lo_next;
	logic [3:0]     bit_reg, bit_next;
	logic [1:0]     idx_reg, idx_next;
	logic           rd_reg, rd_next, oe_n_next, stb_next;
	logic [15:0]    tx_reg, tx_next;
	crc_wr_t        wr_next;
	logic           scl_s, sda_s, rise, fall, start, stop;

	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign rise  = scl_s & ~scl_q_reg;
	assign fall  = ~scl_s & scl_q_reg;
	assign start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
	assign stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

	always_comb begin
		st_next   = st_reg;
		sh_next   = sh_reg;
		cmd_next  = cmd_reg;
		lo_next   = lo_reg;
		bit_next  = bit_reg;
		idx_next  = idx_reg;
		rd_next   = rd_reg;
		tx_next   = tx_reg;
		oe_n_next = sda_oe_n;
		stb_next  = 1'b0;
		wr_next   = wr;
		if (start) begin
			st_next   = SMB_RXB;
			bit_next  = 4'h0;
			idx_next  = 2'h0;
			oe_n_next = 1'b1;
		end else if (stop) begin
			st_next   = SMB_IDLE;
			oe_n_next = 1'b1;
		end else begin
			case (st_reg)
				SMB_RXB: begin
					if (rise) begin
						sh_next  = {sh_reg[6:0], sda_s};
						bit_next = bit_reg + 4'h1;
					end else if (fall && bit_reg == 4'h8) begin
						if (idx_reg == 2'h0 && sh_reg[7:1] != `CRC_SMB_ADDR) begin
							st_next = SMB_IDLE;
						end else begin
							st_next   = SMB_ACK;
							oe_n_next = 1'b0;
							rd_next   = (idx_reg == 2'h0) ? sh_reg[0] : rd_reg;
							case (idx_reg)
								2'h1:    cmd_next = sh_reg;
								2'h2:    lo_next  = sh_reg;
								2'h3: begin
									stb_next = 1'b1;
									wr_next  = '{cmd: cmd_reg, data: {sh_reg, lo_reg}};
								end
								default: ;
							endcase
						end
					end
				end
				SMB_ACK: begin
					if (fall) begin
						bit_next = 4'h0;
						idx_next = idx_reg + 2'h1;
						if (idx_reg == 2'h0 && rd_reg) begin
							st_next   = SMB_TXB;
							tx_next   = {rd_word[6:0], rd_word[15:8], 1'b0};
							oe_n_next = rd_word[7];
						end else if (idx_reg == 2'h3) begin
							st_next   = SMB_IDLE;
							oe_n_next = 1'b1;
						end else begin
							st_next   = SMB_RXB;
							oe_n_next = 1'b1;
						end
					end
				end
				SMB_TXB: begin
					if (fall) begin
						bit_next = bit_reg + 4'h1;
						if (bit_reg == 4'h7) begin
							st_next   = SMB_MACK;
							oe_n_next = 1'b1;
						end else begin
							oe_n_next = tx_reg[15];
							tx_next   = {tx_reg[14:0], 1'b0};
						end
					end
				end
				SMB_MACK: begin
					if (rise) begin
						rd_next = ~sda_s;
					end else if (fall) begin
						bit_next = 4'h0;
						if (rd_reg) begin
							st_next   = SMB_TXB;
							oe_n_next = tx_reg[15];
							tx_next   = {tx_reg[14:0], 1'b0};
						end else begin
							st_next = SMB_IDLE;
						end
					end
				end
				default: begin
					st_next = SMB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_q_reg    <= 1'b1;
			sda_q_reg    <= 1'b1;
			st_reg       <= SMB_IDLE;
			sh_reg       <= 8'h00;
			cmd_reg      <= 8'h00;
			lo_reg       <= 8'h00;
			bit_reg      <= 4'h0;
			idx_reg      <= 2'h0;
			rd_reg       <= 1'b0;
			tx_reg       <= 16'h0000;
			sda_oe_n     <= 1'b1;
			sda_out      <= 1'b0;
			wr_stb       <= 1'b0;
			wr           <= '0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_q_reg    <= scl_s;
			sda_q_reg    <= sda_s;
			st_reg       <= st_next;
			sh_reg       <= sh_next;
			cmd_reg      <= cmd_next;
			lo_reg       <= lo_next;
			bit_reg      <= bit_next;
			idx_reg      <= idx_next;
			rd_reg       <= rd_next;
			tx_reg       <= tx_next;
			sda_oe_n     <= oe_n_next;
			sda_out      <= 1'b0;
			wr_stb       <= stb_next;
			wr           <= wr_next;
		end
	end

	assign rd_cmd = cmd_reg;
endmodule : crc_smbus

// *** sim/crc_host.sv ***
// smbus host model: start, stop and word transfers on an open-drain bus
`timescale 1ns/1ps
module crc_host (
	input  wire logic core_clk, // system clock
	output logic      scl,      // bus clock, host owned
	output logic      sda_lo,   // pulls data low
	input  wire logic sda       // resolved data line
);
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic start();
		sda_lo = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_lo = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(2);
	endtask : start
	task automatic stop();
		sda_lo = 1'b1;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_lo = 1'b0;
		tick(8);
	endtask : stop
	// eight data bits then the ninth, each sampled while clock is high
	task automatic xfer(input logic [8:0] o, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			sda_lo = !o[i];
			tick(8);
			scl = 1'b1;
			tick(8);
			r[i] = sda;
			scl = 1'b0;
			tick(2);
		end
	endtask : xfer
	task automatic wr_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		output logic nak);
		logic [8:0] r0, r1, r2, r3;
		start();
		xfer({a, 2'b01}, r0);
		xfer({c, 1'b1}, r1);
		xfer({d[7:0], 1'b1}, r2);
		xfer({d[15:8], 1'b1}, r3);
		stop();
		nak = r0[0] | r1[0] | r2[0] | r3[0];
	endtask : wr_word
	task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
		logic [8:0] r0, r1;
		start();
		xfer({7'h09, 2'b01}, r0);
		xfer({c, 1'b1}, r0);
		start();
		xfer({7'h09, 2'b11}, r0);
		xfer(9'h1fe, r0);
		xfer(9'h1ff, r1);
		stop();
		d = {r1[8:1], r0[8:1]};
	endtask : rd_word
endmodule : crc_host

// *** sim/crc_ctrl_chk.sv ***
// concurrent checks on the charger control ports
`timescale 1ns/1ps
module crc_ctrl_chk
	import crc_pkg::*;
#(
	parameter int DEGL_CYC = 25000000
) (
	input wire logic        core_clk,   // clock
	input wire logic        rst_n,      // reset
	input wire crc_pins_t   pins,       // levels
	input wire logic [15:0] bat_mv,     // battery mv
	input wire logic        hs_gate_en, // high side
	input wire logic        ls_gate_en, // low side
	input wire logic [6:0]  ichg_ref,   // charge ref
	input wire logic [6:0]  iin_ref,    // input ref
	input wire logic [6:0]  vreg_code,  // cell code
	input wire logic [2:0]  cell_count, // cells
	input wire logic        vor_flag,   // range flag
	input wire logic        shorted     // shorted
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	int          lo_cnt;
	int          hi_cnt;
	logic [15:0] lo_mv;
	logic [15:0] hi_mv;
	assign lo_mv = 16'(cell_count) * 16'd1700;
	assign hi_mv = 16'(cell_count) * 16'd1900;
	// runs of battery below entry or above exit level
	always_ff @(posedge core_clk) begin
		lo_cnt <= (!rst_n || bat_mv >= lo_mv) ? 0 : lo_cnt + 1;
		hi_cnt <= (!rst_n || bat_mv <= hi_mv) ? 0 : hi_cnt + 1;
	end
	sequence on_s;
		!ls_gate_en [*2] ##1 ls_gate_en;
	endsequence
	sequence drop_s;
		hs_gate_en && ls_gate_en ##1 $rose(bat_mv < 16'd2000);
	endsequence
	sequence hot_s;
		pins.hot [*6] ##1 !pins.cool [*6];
	endsequence
	gate_oor_a: assert property (
		(vor_flag && vreg_code == 7'h00) [*3] |-> !hs_gate_en && !ls_gate_en)
		else $error("gate on with bad voltage");
	clamp_top_a: assert property (
		(vor_flag && cell_count == 3'd4 && vreg_code != 7'h00) [*2] |-> vreg_code == 7'h7f)
		else $error("high voltage not clamped");
	wake_pack_a: assert property (
		(cell_count == 3'd2) [*2] |-> vreg_code == 7'h50 && !vor_flag)
		else $error("two cells without wake setting");
	ramp_start_a: assert property (on_s |-> ##2 ichg_ref <= 7'h0f)
		else $error("ramp not restarted");
	fault_off_a: assert property (
		(pins.fault || pins.sleep || pins.uv) [*6] |-> !hs_gate_en && !ls_gate_en)
		else $error("switch on during fault");
	ocp_off_a: assert property (pins.oc [*6] |-> !hs_gate_en)
		else $error("high side on in overcurrent");
	thermal_a: assert property (hot_s |-> !hs_gate_en)
		else $error("converter on while hot");
	low_bat_a: assert property (drop_s |-> ##[1:6] !ls_gate_en)
		else $error("no switch-off on low battery");
	short_in_a: assert property ($rose(shorted) |-> lo_cnt >= DEGL_CYC)
		else $error("short entered early");
	short_out_a: assert property ($fell(shorted) |-> hi_cnt >= DEGL_CYC)
		else $error("short left early");
	fold_back_a: assert property (shorted [*3] |-> ichg_ref <= 7'h0f)
		else $error("no foldback while shorted");
	zero_lim_a: assert property (hs_gate_en [*3] |-> iin_ref != 7'h00)
		else $error("enabled with zero input limit");
endmodule : crc_ctrl_chk
bind crc_ctrl crc_ctrl_chk #(.DEGL_CYC(DEGL_CYC)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.pins(pins), .bat_mv(bat_mv), .hs_gate_en(hs_gate_en), .ls_gate_en(ls_gate_en),
	.ichg_ref(ichg_ref), .iin_ref(iin_ref), .vreg_code(vreg_code), .cell_count(cell_count),
	.vor_flag(vor_flag), .shorted(shorted));

// *** sim/tb_crc_ctrl.sv ***
// self-checking bench for the charger control block
`timescale 1ns/1ps
module tb_crc_ctrl
	import crc_pkg::*;
;
	localparam int STEP = 200;
	logic        core_clk, rst_n, scl, sda_lo, sda, sda_out, sda_oe_n, nak;
	logic        hs_gate_en, ls_gate_en, mon_sel, vor_flag, depleted, shorted;
	crc_pins_t   pins;
	logic [15:0] bat_mv, d;
	logic [6:0]  ichg_ref, iin_ref, vreg_code;
	logic [2:0]  cell_count;
	int          fail_count, num_checks, n;
	// mv, code, cells, flag, enable
	logic [31:0] vt [10] = '{32'h2af8_0032, 32'h3840_0042, 32'h3e7e_0042, 32'h2328_5021,
		32'h2ee0_0031, 32'h32c8_3531, 32'h382d_7e31, 32'h4b00_7f43, 32'h4ace_7e41,
		32'h3e80_0041};
	crc_ctrl #(.STEP_CYC(STEP), .DEGL_CYC(50)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pins(pins),
		.bat_mv(bat_mv), .hs_gate_en(hs_gate_en), .ls_gate_en(ls_gate_en),
		.ichg_ref(ichg_ref), .iin_ref(iin_ref), .vreg_code(vreg_code),
		.cell_count(cell_count), .mon_sel(mon_sel), .vor_flag(vor_flag),
		.depleted(depleted), .shorted(shorted));
	crc_host host (.core_clk(core_clk), .scl(scl), .sda_lo(sda_lo), .sda(sda));
	assign sda = (sda_oe_n ? 1'b1 : sda_out) & !sda_lo;
	always #20 core_clk = !core_clk;
	task automatic wt(input int k);
		repeat (k) @(negedge core_clk);
	endtask : wt
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		host.wr_word(7'h09, c, v, nak);
		chk(16'(nak), 16'h0000);
		wt(8);
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		host.rd_word(c, d);
		chk(d, exp);
	endtask : rd
	task automatic ramp();
		for (int k = 1; k <= 8; k++) begin
			chk(16'(ichg_ref), 16'(8 * k));
			wt(STEP);
		end
	endtask : ramp
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	initial begin
		#3_000_000;
		fail_count++;
		summarize();
	end
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		pins = 6'h01;
		bat_mv = 16'd9000;
		fail_count = 0;
		num_checks = 0;
		wt(5);
		rst_n = 1'b1;
		wt(8);
		rd(8'h12, 16'h0000);
		rd(8'h14, 16'h0000);
		rd(8'h3f, 16'h0000);
		rd(8'h20, 16'h0000);
		host.wr_word(7'h0a, 8'h14, 16'h2000, nak);
		chk(16'(nak), 16'h0001);
		wr(8'h3f, 16'hffff);
		wr(8'h14, 16'h2000);
		for (int i = 0; i < 10; i++) begin
			wr(8'h15, vt[i][31:16]);
			chk(16'(vreg_code), 16'(vt[i][14:8]));
			chk(16'(cell_count), 16'(vt[i][6:4]));
			chk(16'(vor_flag), 16'(vt[i][1]));
			chk(16'(ls_gate_en), 16'(vt[i][0]));
		end
		chk(16'(iin_ref), 16'h007f);
		wr(8'h3f, 16'h0400);
		chk(16'(iin_ref), 16'h0008);
		wr(8'h14, 16'h0000);
		chk(16'(ls_gate_en), 16'h0000);
		wr(8'h14, 16'h2000);
		wt(50);
		ramp();
		wr(8'h12, 16'h0608);
		chk(16'(mon_sel), 16'h0001);
		chk(16'(depleted), 16'h0001);
		rd(8'h12, 16'h0608);
		wr(8'h12, 16'h0000);
		chk(16'(mon_sel), 16'h0000);
		chk(16'(depleted), 16'h0000);
		wr(8'h16, 16'hffff);
		rd(8'h16, 16'h0006);
		for (int i = 3; i <= 5; i++) begin
			pins[i] = 1'b1;
			wt(8);
			chk(16'({hs_gate_en, ls_gate_en}), 16'h0000);
			pins[i] = 1'b0;
		end
		wt(100);
		ramp();
		pins.oc = 1'b1;
		wt(8);
		chk(16'({hs_gate_en, ls_gate_en}), 16'h0001);
		pins.oc = 1'b0;
		wt(8);
		chk(16'(hs_gate_en), 16'h0001);
		pins = 6'h02;
		wt(8);
		chk(16'(hs_gate_en), 16'h0000);
		pins = 6'h00;
		wt(8);
		chk(16'(hs_gate_en), 16'h0000);
		pins = 6'h01;
		wt(8);
		chk(16'(hs_gate_en), 16'h0001);
		wt(1700);
		bat_mv = 16'd1500;
		n = 0;
		for (int i = 0; i < 10; i++) begin
			wt(1);
			if (ls_gate_en !== 1'b1) n++;
		end
		chk(16'(n), 16'h0001);
		wt(20);
		chk(16'(shorted), 16'h0000);
		wt(40);
		chk(16'(shorted), 16'h0001);
		wt(1700);
		chk(16'(ichg_ref), 16'h0008);
		bat_mv = 16'd8000;
		wt(30);
		chk(16'(shorted), 16'h0001);
		wt(40);
		chk(16'(shorted), 16'h0000);
		wt(10);
		chk(16'(ichg_ref), 16'h0040);
		chk(16'(depleted), 16'h0001);
		wr(8'h15, 16'd9000);
		bat_mv = 16'd4000;
		wt(8);
		chk(16'(depleted), 16'h0001);
		bat_mv = 16'd5000;
		wt(8);
		chk(16'(depleted), 16'h0000);
		summarize();
	end
endmodule : tb_crc_ctrl
